// ---- design/csr_pkg.sv ----
// Constants shared by the capability and soft reset register block.
// Assumes a 200 MHz core clock and 8-bit register addresses from the
// control command decoder.
package csr_pkg;

    // =====================================================================
    // Register map
    // =====================================================================
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 32;
    localparam logic [7:0]  ADDR_CAPABILITY = 8'h02;
    localparam logic [7:0]  ADDR_SOFT_RESET = 8'h03;

    // =====================================================================
    // Capability fields
    // =====================================================================
    localparam int          FRAME_TIMESTAMP_CAPABLE_BIT        = 6;
    localparam int          ADDR_INCR_DISABLE_CAPABLE_BIT        = 5;
    localparam int          CHUNK_SEQUENCE_RETRY_CAPABLE_BIT        = 4;
    localparam int          MIN_CHUNK_PAYLOAD_CODE_LSB      = 0;
    localparam logic        FRAME_TIMESTAMP_CAPABLE_VALUE      = 1'b1;
    localparam logic        ADDR_INCR_DISABLE_CAPABLE_VALUE      = 1'b0;
    localparam logic        CHUNK_SEQUENCE_RETRY_CAPABLE_VALUE      = 1'b0;
    localparam logic [2:0]  MIN_CHUNK_PAYLOAD_CODE_VALUE    = 3'h3;
    localparam logic [31:0] CAP_VALUE       =
        (32'(FRAME_TIMESTAMP_CAPABLE_VALUE) << FRAME_TIMESTAMP_CAPABLE_BIT) |
        (32'(ADDR_INCR_DISABLE_CAPABLE_VALUE) << ADDR_INCR_DISABLE_CAPABLE_BIT) |
        (32'(CHUNK_SEQUENCE_RETRY_CAPABLE_VALUE) << CHUNK_SEQUENCE_RETRY_CAPABLE_BIT) |
        (32'(MIN_CHUNK_PAYLOAD_CODE_VALUE) << MIN_CHUNK_PAYLOAD_CODE_LSB);

    // =====================================================================
    // Soft reset register
    // =====================================================================
    localparam int          SOFT_RESET_TRIGGER_BIT     = 0;
    localparam logic [31:0] SOFT_RESET_READ = 32'h0000_0000;
    localparam logic [31:0] READ_ZERO       = 32'h0000_0000;

    // =====================================================================
    // Timing
    // =====================================================================
    localparam int CLOCK_PERIOD_PS  = 5000;
    localparam int CS_MIN_HOLD_NS   = 100;
    localparam int CS_HOLD_CYCLES   =
        (CS_MIN_HOLD_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
    localparam int RESET_PULSE_DEF  = 8;

    // =====================================================================
    // Soft reset sequencer states
    // =====================================================================
    typedef enum logic [1:0] {
        CSR_IDLE,
        CSR_ARMED,
        CSR_RESETTING
    } csr_state_t;

endpackage

// ---- design/csr_hold_counter.sv ----
// Saturating cycle counter that flags when a limit has been reached.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none

module csr_hold_counter #(
    parameter int LIMIT = 20
) (
    // Clock and reset.
    input  wire logic i_clock,
    input  wire logic i_resetn,
    // Control.
    input  wire logic i_clear,
    input  wire logic i_count,
    // Status.
    output logic      o_reached
);
    localparam int WIDTH = $clog2(LIMIT + 1);
    localparam logic [WIDTH-1:0] LIM = WIDTH'(LIMIT);
    localparam logic [WIDTH-1:0] ONE = WIDTH'(1);

    // Elaboration check: a zero limit would leave the flag stuck high.
    if (LIMIT < 1) begin : g_limit_check
        $error("csr_hold_counter LIMIT must be at least 1.");
    end

    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;

    // Clear wins; counting stops at the limit so it cannot wrap.
    always_comb begin
        next_count = count;
        if (i_clear) begin
            next_count = '0;
        end else if (i_count && (count < LIM)) begin
            next_count = count + ONE;
        end
    end

    // Register the count.
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    assign o_reached = (count >= LIM);

endmodule

`default_nettype wire

// ---- design/csr_regs.sv ----
// Capability register and software reset sequencer of the MAC-PHY
// register map, reached through control command word accesses.
// Assumes a command decoder that presents one word access per pulse while
// chip select is low, all inputs synchronous to i_clock.
`timescale 1ns/1ps
`default_nettype none

module csr_regs #(
    parameter int RESET_PULSE_CYCLES = csr_pkg::RESET_PULSE_DEF
) (
    // Clock and reset.
    input  wire logic        i_clock,
    input  wire logic        i_resetn,
    // Serial interface framing.
    input  wire logic        i_cs_n,
    // Control command start.
    input  wire logic        i_cmd_start,
    input  wire logic [7:0]  i_cmd_addr,
    input  wire logic        i_addr_incr_disable_flag,
    // Word accesses.
    input  wire logic        i_word_wr,
    input  wire logic [31:0] i_word_wdata,
    input  wire logic        i_word_rd,
    output logic [31:0]      o_word_rdata,
    output logic             o_word_rvalid,
    // Configuration status.
    input  wire logic        i_sync_set,
    input  wire logic        i_reset_complete_clear,
    output logic             o_config_sync_flag,
    output logic             o_reset_complete_flag,
    output logic             o_interrupt_request_pin_n,
    // Device-wide reset.
    output logic             o_device_reset_n
);
    // Elaboration check: the pulse counter needs a limit of at least one.
    if (RESET_PULSE_CYCLES < 2) begin : g_pulse_check
        $error("RESET_PULSE_CYCLES must be at least 2.");
    end

    localparam logic [7:0] ADDR_ONE = 8'h01;

    // =====================================================================
    // Word address pointer and read path
    // =====================================================================
    logic [7:0]  ptr;
    logic [7:0]  next_ptr;
    logic [31:0] next_rdata;
    logic        next_rvalid;
    logic        busy;

    // The disable request is accepted on the port but deliberately not
    // honoured, because the capability says increment cannot be turned off.
    always_comb begin
        next_ptr    = ptr;
        next_rdata  = o_word_rdata;
        next_rvalid = 1'b0;
        if (busy) begin
            next_ptr = '0;
        end else if (i_cmd_start) begin
            next_ptr = i_cmd_addr;
        end else if (i_word_wr || i_word_rd) begin
            next_ptr = ptr + ADDR_ONE;
        end
        if (!busy && !i_cmd_start && i_word_rd) begin
            next_rvalid = 1'b1;
            case (ptr)
                csr_pkg::ADDR_CAPABILITY:
                    next_rdata = csr_pkg::CAP_VALUE;
                csr_pkg::ADDR_SOFT_RESET:
                    next_rdata = csr_pkg::SOFT_RESET_READ;
                default:
                    next_rdata = csr_pkg::READ_ZERO;
            endcase
        end
    end

    // Register pointer and read data.
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            ptr           <= '0;
            o_word_rdata  <= '0;
            o_word_rvalid <= 1'b0;
        end else begin
            ptr           <= next_ptr;
            o_word_rdata  <= next_rdata;
            o_word_rvalid <= next_rvalid;
        end
    end

    // =====================================================================
    // Soft reset sequencer
    // =====================================================================
    csr_pkg::csr_state_t state;
    csr_pkg::csr_state_t next_state;
    logic                hold_ok;
    logic                pulse_done;
    logic                reset_req;

    // Writes to the capability address fall through and change nothing.
    assign reset_req = !busy && !i_cmd_start && i_word_wr && !i_cs_n &&
                       (ptr == csr_pkg::ADDR_SOFT_RESET) &&
                       i_word_wdata[csr_pkg::SOFT_RESET_TRIGGER_BIT];
    assign busy = (state == csr_pkg::CSR_RESETTING);

    // Chip select low time is measured so a too-short frame cannot fire.
    csr_hold_counter #(
        .LIMIT (csr_pkg::CS_HOLD_CYCLES)
    ) u_cs_hold (
        .i_clock   (i_clock),
        .i_resetn  (i_resetn),
        .i_clear   (i_cs_n),
        .i_count   (!i_cs_n),
        .o_reached (hold_ok)
    );

    csr_hold_counter #(
        .LIMIT (RESET_PULSE_CYCLES - 1)
    ) u_pulse (
        .i_clock   (i_clock),
        .i_resetn  (i_resetn),
        .i_clear   (!busy),
        .i_count   (busy),
        .o_reached (pulse_done)
    );

    // The reset is held back until the frame ends, so the command write that
    // requested it completes and its answer reaches the host first.
    always_comb begin
        next_state = state;
        case (state)
            csr_pkg::CSR_IDLE: begin
                if (reset_req) begin
                    next_state = csr_pkg::CSR_ARMED;
                end
            end
            csr_pkg::CSR_ARMED: begin
                if (i_cs_n) begin
                    if (hold_ok) begin
                        next_state = csr_pkg::CSR_RESETTING;
                    end else begin
                        next_state = csr_pkg::CSR_IDLE;
                    end
                end
            end
            csr_pkg::CSR_RESETTING: begin
                if (pulse_done) begin
                    next_state = csr_pkg::CSR_IDLE;
                end
            end
            default: begin
                next_state = csr_pkg::CSR_IDLE;
            end
        endcase
    end

    // Register the sequencer state.
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            state <= csr_pkg::CSR_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // The device reset is a flop so it cannot glitch on state decoding.
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_device_reset_n <= 1'b1;
        end else begin
            o_device_reset_n <= (next_state != csr_pkg::CSR_RESETTING);
        end
    end

    // =====================================================================
    // Configuration sync and reset-complete flags
    // =====================================================================
    logic next_sync;
    logic next_reset_complete_flag;

    // Reset wins over the host: a clear in the same cycle is lost.
    always_comb begin
        next_sync   = o_config_sync_flag;
        next_reset_complete_flag = o_reset_complete_flag;
        if (i_sync_set) begin
            next_sync = 1'b1;
        end
        if (i_reset_complete_clear) begin
            next_reset_complete_flag = 1'b0;
        end
        if (busy) begin
            next_sync   = 1'b0;
            next_reset_complete_flag = 1'b1;
        end
    end

    // Power-on reset leaves the flags in their post-reset state directly.
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_config_sync_flag    <= 1'b0;
            o_reset_complete_flag <= 1'b1;
        end else begin
            o_config_sync_flag    <= next_sync;
            o_reset_complete_flag <= next_reset_complete_flag;
        end
    end

    assign o_interrupt_request_pin_n = !o_reset_complete_flag;

    // =====================================================================
    // Assertions
    // =====================================================================
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_resetn);

    a_frame_timestamp_capable_reads_one: assert property (
        i_word_rd && !i_cmd_start && !busy &&
        ptr == csr_pkg::ADDR_CAPABILITY
        |=> o_word_rvalid && o_word_rdata[csr_pkg::FRAME_TIMESTAMP_CAPABLE_BIT])
        else $error("Timestamp capability did not read one.");

    a_addr_post_incr: assert property (
        (i_word_wr || i_word_rd) && !i_cmd_start && !busy
        |=> ptr == $past(ptr) + ADDR_ONE)
        else $error("Word address did not post-increment.");

    a_seq_addr_incr_disable_capable_zero: assert property (
        o_word_rvalid && $past(ptr) == csr_pkg::ADDR_CAPABILITY
        |-> !o_word_rdata[csr_pkg::CHUNK_SEQUENCE_RETRY_CAPABLE_BIT] &&
            !o_word_rdata[csr_pkg::ADDR_INCR_DISABLE_CAPABLE_BIT])
        else $error("Sequence or increment capability read nonzero.");

    a_min_payload: assert property (
        o_word_rvalid && $past(ptr) == csr_pkg::ADDR_CAPABILITY
        |-> o_word_rdata[csr_pkg::MIN_CHUNK_PAYLOAD_CODE_LSB +: $bits(csr_pkg::MIN_CHUNK_PAYLOAD_CODE_VALUE)]
            == csr_pkg::MIN_CHUNK_PAYLOAD_CODE_VALUE)
        else $error("Minimum payload code is not three.");

    a_reset_fires: assert property (
        state == csr_pkg::CSR_ARMED && i_cs_n && hold_ok
        |=> !o_device_reset_n ##1 !o_device_reset_n)
        else $error("Soft reset did not assert after chip select release.");

    a_reset_waits_cs: assert property (
        state == csr_pkg::CSR_ARMED && !i_cs_n |=> o_device_reset_n)
        else $error("Soft reset fired while chip select was low.");

    a_short_cs_drop: assert property (
        state == csr_pkg::CSR_ARMED && i_cs_n && !hold_ok
        |=> o_device_reset_n && state == csr_pkg::CSR_IDLE)
        else $error("Soft reset fired after a too-short frame.");

    a_soft_reset_trigger_reads_zero: assert property (
        o_word_rvalid && $past(ptr) == csr_pkg::ADDR_SOFT_RESET
        |-> o_word_rdata == csr_pkg::SOFT_RESET_READ)
        else $error("Soft reset register read nonzero.");

    a_post_reset_flags: assert property (
        $rose(o_device_reset_n)
        |-> o_reset_complete_flag && !o_config_sync_flag &&
            !o_interrupt_request_pin_n)
        else $error("Flags wrong after soft reset.");

    a_cap_write_ignored: assert property (
        i_word_wr && !i_cmd_start && !busy &&
        ptr == csr_pkg::ADDR_CAPABILITY && state == csr_pkg::CSR_IDLE
        |=> state == csr_pkg::CSR_IDLE)
        else $error("Capability write changed device state.");

    c_soft_reset: cover property ($fell(o_device_reset_n));
    c_cap_read: cover property (
        o_word_rvalid && $past(ptr) == csr_pkg::ADDR_CAPABILITY);
    c_short_frame: cover property (
        state == csr_pkg::CSR_ARMED && i_cs_n && !hold_ok);
    c_sync_set: cover property ($rose(o_config_sync_flag));
    // The disable request is only observed here; the pointer ignores it.
    c_incr_forced: cover property (
        i_addr_incr_disable_flag && i_word_rd && !i_cmd_start && !busy);

endmodule

`default_nettype wire

// ---- tb/csr_host_model.sv ----
// Behavioural host that issues control commands to the register block.
// Assumes one core clock; all outputs change by non-blocking assignment
// just after a rising edge and are held until the next edge.
`timescale 1ns/1ps
`default_nettype none

module csr_host_model (
    // Clock.
    input  wire logic        i_clock,
    // Read answer.
    input  wire logic [31:0] i_rdata,
    input  wire logic        i_rvalid,
    // Framing and commands.
    output logic             o_cs_n,
    output logic             o_cmd_start,
    output logic [7:0]       o_cmd_addr,
    output logic             o_aid,
    // Word accesses.
    output logic             o_wr,
    output logic [31:0]      o_wdata,
    output logic             o_rd,
    // Configuration pulses.
    output logic             o_sync_set,
    output logic             o_rc_clear
);
    // =====================================================================
    // Frame length tracking
    // =====================================================================
    int cs_cycles;

    // Counts edges with chip select low, to hold frames long enough.
    always @(posedge i_clock) begin
        cs_cycles <= o_cs_n ? 0 : cs_cycles + 1;
    end

    // All lines idle at time zero.
    initial begin
        o_cs_n      = 1'b1;
        o_cmd_start = 1'b0;
        o_cmd_addr  = 8'h00;
        o_aid       = 1'b0;
        o_wr        = 1'b0;
        o_wdata     = 32'h0000_0000;
        o_rd        = 1'b0;
        o_sync_set  = 1'b0;
        o_rc_clear  = 1'b0;
    end

    // =====================================================================
    // Host operations
    // =====================================================================
    task automatic open_frame();
        @(posedge i_clock);
        o_cs_n <= 1'b0;
    endtask

    // A zero minimum gives a deliberately short frame.
    task automatic close_frame(input int min_cycles);
        @(posedge i_clock);
        while (cs_cycles < min_cycles) begin
            @(posedge i_clock);
        end
        o_cs_n <= 1'b1;
        @(posedge i_clock);
    endtask

    // Released address lines show the inverse so stale values never match.
    task automatic start_cmd(input logic [7:0] a, input logic addr_incr_disable_flag);
        @(posedge i_clock);
        o_cmd_start <= 1'b1;
        o_cmd_addr  <= a;
        o_aid       <= addr_incr_disable_flag;
        @(posedge i_clock);
        o_cmd_start <= 1'b0;
        o_cmd_addr  <= ~a;
    endtask

    task automatic wr_word(input logic [31:0] d);
        @(posedge i_clock);
        o_wr    <= 1'b1;
        o_wdata <= d;
        @(posedge i_clock);
        o_wr    <= 1'b0;
        o_wdata <= ~d;
    endtask

    // The answer is taken just after the edge that samples the request.
    task automatic rd_word(output logic [31:0] d, output logic v);
        @(posedge i_clock);
        o_rd <= 1'b1;
        @(posedge i_clock);
        o_rd <= 1'b0;
        #1;
        v = i_rvalid;
        d = i_rdata;
    endtask

    task automatic pulse_cfg(input logic s, input logic c);
        @(posedge i_clock);
        o_sync_set <= s;
        o_rc_clear <= c;
        @(posedge i_clock);
        o_sync_set <= 1'b0;
        o_rc_clear <= 1'b0;
    endtask
endmodule

`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the capability and soft reset registers.
// Assumes the host model drives every command input of the block.
`timescale 1ns/1ps
`default_nettype none

module testbench;
    // =====================================================================
    // Signals
    // =====================================================================
    localparam int PULSE = 5;
    logic        i_clock;
    logic        i_resetn;
    // Nets between the host model and the block, driven by the instances.
    wire logic        cs_n, start, addr_incr_disable_flag, wr, rd, sset, rclr;
    wire logic [7:0]  addr;
    wire logic [31:0] wdata, rdata;
    wire logic        rvalid, sync, rc, irq_n, dev_rst_n;
    logic [31:0]      d;
    logic             v;
    int          fail_count, samples_checked, n;

    // =====================================================================
    // Instances
    // =====================================================================
    csr_host_model host_u (
        .i_clock(i_clock), .i_rdata(rdata), .i_rvalid(rvalid),
        .o_cs_n(cs_n), .o_cmd_start(start), .o_cmd_addr(addr),
        .o_aid(addr_incr_disable_flag), .o_wr(wr), .o_wdata(wdata), .o_rd(rd),
        .o_sync_set(sset), .o_rc_clear(rclr)
    );

    csr_regs #(.RESET_PULSE_CYCLES(PULSE)) dut_u (
        .i_clock(i_clock), .i_resetn(i_resetn), .i_cs_n(cs_n),
        .i_cmd_start(start), .i_cmd_addr(addr),
        .i_addr_incr_disable_flag(addr_incr_disable_flag), .i_word_wr(wr),
        .i_word_wdata(wdata), .i_word_rd(rd), .o_word_rdata(rdata),
        .o_word_rvalid(rvalid), .i_sync_set(sset),
        .i_reset_complete_clear(rclr), .o_config_sync_flag(sync),
        .o_reset_complete_flag(rc), .o_interrupt_request_pin_n(irq_n),
        .o_device_reset_n(dev_rst_n)
    );

    // Free-running 200 MHz clock.
    initial begin
        i_clock = 1'b0;
        forever #2.5 i_clock = ~i_clock;
    end

    // =====================================================================
    // Checking and reporting
    // =====================================================================
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen 0x%h expected 0x%h",
                     $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // =====================================================================
    // Scenarios
    // =====================================================================
    // Status after power-on reset.
    task automatic t_reset_state();
        check(32'(sync), 32'h0);
        check(32'(rc), 32'h1);
        check(32'(irq_n), 32'h0);
        check(32'(dev_rst_n), 32'h1);
    endtask

    // Two-word read with the disable request set: pointer still moves.
    task automatic t_cap_read();
        host_u.open_frame();
        host_u.start_cmd(csr_pkg::ADDR_CAPABILITY, 1'b1);
        host_u.rd_word(d, v);
        check(32'(v), 32'h1);
        check(32'(d[6]), 32'h1);
        check(32'(d[5]), 32'h0);
        check(32'(d[4]), 32'h0);
        check(32'(d[2:0]), 32'h3);
        check(d, 32'h0000_0043);
        host_u.rd_word(d, v);
        check(32'(v), 32'h1);
        check(d, 32'h0000_0000);
        host_u.close_frame(30);
    endtask

    // A write of all ones to the capability word changes nothing.
    task automatic t_cap_write();
        host_u.open_frame();
        host_u.start_cmd(csr_pkg::ADDR_CAPABILITY, 1'b0);
        host_u.wr_word(32'hFFFF_FFFF);
        host_u.start_cmd(csr_pkg::ADDR_CAPABILITY, 1'b0);
        host_u.rd_word(d, v);
        check(d, 32'h0000_0043);
        host_u.close_frame(30);
    endtask

    // Configure, then a too-short frame must not reset the device.
    task automatic t_short_frame();
        host_u.pulse_cfg(1'b1, 1'b1);
        #1;
        check(32'(sync), 32'h1);
        check(32'(rc), 32'h0);
        check(32'(irq_n), 32'h1);
        host_u.open_frame();
        host_u.start_cmd(csr_pkg::ADDR_SOFT_RESET, 1'b0);
        host_u.wr_word(32'h0000_0001);
        host_u.close_frame(0);
        repeat (12) @(posedge i_clock);
        #1;
        check(32'(dev_rst_n), 32'h1);
        check(32'(sync), 32'h1);
    endtask

    // Reset reached by post-increment; it waits for chip select release.
    task automatic t_soft_reset();
        host_u.open_frame();
        host_u.start_cmd(csr_pkg::ADDR_CAPABILITY, 1'b1);
        host_u.wr_word(32'h0000_0000);
        host_u.wr_word(32'h0000_0001);
        repeat (6) @(posedge i_clock);
        #1;
        check(32'(dev_rst_n), 32'h1);
        host_u.close_frame(30);
        n = 0;
        while (dev_rst_n !== 1'b0 && n < 6) begin
            @(posedge i_clock);
            #1;
            n++;
        end
        check(32'(dev_rst_n), 32'h0);
        // The release edge launches the reset, so it is seen one edge on.
        check(32'(n), 32'h1);
        // The first low cycle has already been seen, so counting starts at 1.
        n = 1;
        while (dev_rst_n === 1'b0 && n < 40) begin
            @(posedge i_clock);
            #1;
            n++;
        end
        check(32'(n), 32'(PULSE));
        check(32'(sync), 32'h0);
        check(32'(rc), 32'h1);
        check(32'(irq_n), 32'h0);
        host_u.open_frame();
        host_u.start_cmd(csr_pkg::ADDR_SOFT_RESET, 1'b0);
        host_u.rd_word(d, v);
        check(d, 32'h0000_0000);
        host_u.close_frame(30);
    endtask

    // =====================================================================
    // Main sequence and watchdog
    // =====================================================================
    initial begin
        fail_count = 0;
        samples_checked = 0;
        i_resetn = 1'b0;
        repeat (12) @(posedge i_clock);
        i_resetn <= 1'b1;
        @(posedge i_clock);
        #1;
        t_reset_state();
        t_cap_read();
        t_cap_write();
        t_short_frame();
        t_soft_reset();
        final_report();
    end

    // The whole run needs well under a thousand cycles.
    initial begin
        #20000;
        fail_count++;
        final_report();
    end
endmodule

`default_nettype wire
